// *** common/mwmi_params.svh ***
/*
 * constants of the masked-write / mask-invert lane block: register offsets,
 * field positions, reset values, command codes and burst counts.
 * assumes it is included by its bare name before any user of the macros.
 */
`ifndef MWMI_PARAMS_SVH
`define MWMI_PARAMS_SVH

// ****************************************************************
// register byte offsets on the apb bus
// ****************************************************************
`define MWMI_OFF_MR3 12'h000
`define MWMI_OFF_MODE_REGISTER_THIRTEEN 12'h004
`define MWMI_OFF_CFG 12'h008
`define MWMI_OFF_STAT 12'h00C

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define MWMI_MR3_RDBI_BIT 6
`define MWMI_MR3_WDBI_BIT 7
`define MWMI_MODE_REGISTER_THIRTEEN_DM_BIT 5
`define MWMI_CFG_BL32_BIT 0
`define MWMI_STAT_ILL_BIT 0
`define MWMI_MR3_RST 8'h00
`define MWMI_MODE_REGISTER_THIRTEEN_RST 8'h00
`define MWMI_CFG_RST 1'h0

// ****************************************************************
// command codes on the command pins (first part, then second part)
// ****************************************************************
`define MWMI_CMD_WR1 4'h1
`define MWMI_CMD_MW1 4'h2
`define MWMI_CMD_RD1 4'h3
`define MWMI_CMD_MRR 4'h4
`define MWMI_CMD_MRW 4'h5
`define MWMI_CMD_WRFIFO 4'h6
`define MWMI_CMD_RDFIFO 4'h7
`define MWMI_CMD_RDCAL 4'h8
`define MWMI_CMD_CAS2 4'h9

// ****************************************************************
// burst and spacing counts (link clocks) and ones-count thresholds
// ****************************************************************
`define MWMI_LAST_BEAT16 6'h0F
`define MWMI_LAST_BEAT32 6'h1F
`define MWMI_MASKED_WRITE_SPACING 32
`define MWMI_BL32_EXTRA 8
`define MWMI_CCD_BL16 8
`define MWMI_CCD_BL32 16
`define MWMI_MW_HI6_MIN 4'h5
`define MWMI_RD_INV_ABOVE 4'h4

`endif

// *** common/mwmi_pkg.sv ***
/*
 * types shared by the masked-write / mask-invert lane block.
 * assumes nothing beyond a systemverilog compiler.
 */
package mwmi_pkg;

	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_PEND = 3'b010,
		S_BURST = 3'b100
	} mwmi_state_t;

	typedef enum logic [2:0] {
		K_WR = 3'h0,
		K_MW = 3'h1,
		K_MRW = 3'h2,
		K_WRFIFO = 3'h3,
		K_RD = 3'h4,
		K_MRR = 3'h5,
		K_RDFIFO = 3'h6,
		K_RDCAL = 3'h7
	} mwmi_kind_t;

	function automatic logic [3:0] mwmi_ones8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

endpackage

// *** logic/mwmi_top.sv ***
/*
 * device-side lane logic for masked writes and the per-byte mask/invert pins:
 * two-part command decode, write beat capture with masking and inversion,
 * read data inversion, and an apb register file holding the mode bits.
 * assumes the command clock, strobe and pins are asynchronous to clk_sys_in
 * and slow enough (link period 200 ns) to be oversampled; the array side
 * consumes beats on wr_valid_out and supplies read beats on rd_valid_in.
 */
//
// Contract
// - masked write is a first command cycle followed by the second column cycle.
// - masked writes are always 16-beat bursts, whatever burst length is set.
// - one mask/invert pin per byte lane, two per channel, timed like data.
// - mask/invert pin carries ddr values sampled with its lane's data.
// - masking only on writes; inversion on reads, writes, mode accesses; per lane.
// - read inversion enabled by mode register three bit 6.
// - write inversion enabled by mode register three bit 7.
// - byte masking enabled through mode register thirteen bit 5.
// - all functions off: pin ignored on writes, high-impedance on reads.
// - masking off makes masked write illegal; any function on gives training.
// - masking on, write inversion off: pin ignored on writes, mask on masked.
// - masking and write inversion on: pin is inversion flag on writes.
// - write inversion inverts a byte when its pin samples high.
// - read inversion inverts a byte with more than four ones, pin high.
// - masking alone: high pin drops that beat of that byte.
// - both on: pin low and five or more ones on upper six lines masks.
`timescale 1ns/1ps
`include "mwmi_params.svh"

module mwmi_top
	import mwmi_pkg::*;
(
	input wire logic clk_sys_in, // system clock, 40 MHz
	input wire logic reset_in, // synchronous reset, active high
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error on unmapped address
	input wire logic link_clk_in, // command clock pin
	input wire logic [3:0] cmd_in, // command pins
	input wire logic dqs_in, // write data strobe pin
	input wire logic [15:0] dq_in, // data pins, input side
	output logic [15:0] dq_out, // data pins, output side
	output logic dq_oe_out, // data pins drive enable
	input wire logic [1:0] dmi_in, // mask/invert pins, input side
	output logic [1:0] dmi_out, // mask/invert pins, output side
	output logic [1:0] dmi_oe_out, // mask/invert pins drive enable
	output logic wr_valid_out, // write beat to the array
	output logic [15:0] wr_data_out, // write beat data after inversion
	output logic [1:0] wr_mask_out, // per-byte mask for the beat
	output logic [1:0] wr_dmi_out, // training bits on write fifo beats
	output logic [2:0] wr_kind_out, // kind of the burst the beat belongs to
	input wire logic rd_valid_in, // read beat from the array
	input wire logic [15:0] rd_data_in, // read beat data
	input wire logic [1:0] rd_dmi_in // training pattern for training reads
);

	typedef struct packed {
		mwmi_state_t fsm;
		mwmi_kind_t kind;
		logic [2:0] lk_sync;
		logic [3:0] cmd_m;
		logic [3:0] cmd_q;
		logic [2:0] dqs_sync;
		logic [15:0] dq_m;
		logic [15:0] dq_q;
		logic [1:0] dmi_m;
		logic [1:0] dmi_q;
		logic [5:0] beat;
		logic [5:0] last_beat;
		logic cap_v;
		logic [15:0] cap_dq;
		logic [1:0] cap_dmi;
		logic [7:0] mr3;
		logic [7:0] mode_register_thirteen;
		logic bl32;
		logic illegal;
		logic rd_train;
		logic wr_valid;
		logic [15:0] wr_data;
		logic [1:0] wr_mask;
		logic [1:0] wr_dmi;
		logic [15:0] dq_o;
		logic dq_oe;
		logic [1:0] dmi_o;
		logic [1:0] dmi_oe;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} mwmi_st_t;

	localparam mwmi_st_t ST_RST = '{
		fsm: S_IDLE,
		kind: K_WR,
		mr3: `MWMI_MR3_RST,
		mode_register_thirteen: `MWMI_MODE_REGISTER_THIRTEEN_RST,
		bl32: `MWMI_CFG_RST,
		default: '0
	};

	mwmi_st_t st_r;
	mwmi_st_t st_nxt;

	logic wdbi;
	logic rdbi;
	logic dm_en;
	logic any_fn;
	logic [15:0] ln_wdata;
	logic [1:0] ln_wmask;
	logic [15:0] ln_rdata;
	logic [1:0] ln_rdmi;

	assign rdbi = st_r.mr3[`MWMI_MR3_RDBI_BIT];
	assign wdbi = st_r.mr3[`MWMI_MR3_WDBI_BIT];
	assign dm_en = ~st_r.mode_register_thirteen[`MWMI_MODE_REGISTER_THIRTEEN_DM_BIT];
	assign any_fn = wdbi | rdbi | dm_en;

	// ****************************************************************
	// per-lane write decode and read inversion
	// ****************************************************************
	for (genvar g = 0; g < 2; g++) begin : g_lane
		logic [7:0] wbyte;
		logic [7:0] rbyte;
		logic wpin;
		logic mw_dbi_mask;
		logic rinv;
		assign wbyte = st_r.cap_dq[8*g +: 8];
		assign wpin = st_r.cap_dmi[g];
		assign rbyte = rd_data_in[8*g +: 8];
		assign mw_dbi_mask = ~wpin && (mwmi_ones8({2'h0, wbyte[7:2]}) >= `MWMI_MW_HI6_MIN);
		assign rinv = mwmi_ones8(rbyte) > `MWMI_RD_INV_ABOVE;
		always_comb begin
			ln_wmask[g] = 1'b0;
			ln_wdata[8*g +: 8] = wbyte;
			unique case (st_r.kind)
				K_MW: begin
					if (wdbi) begin
						ln_wmask[g] = mw_dbi_mask;
						ln_wdata[8*g +: 8] = (!mw_dbi_mask && wpin) ? ~wbyte : wbyte;
					end else begin
						ln_wmask[g] = wpin;
					end
				end
				K_WR, K_MRW: begin
					ln_wdata[8*g +: 8] = (wdbi && wpin) ? ~wbyte : wbyte;
				end
				default: ln_wdata[8*g +: 8] = wbyte;
			endcase
		end
		assign ln_rdata[8*g +: 8] = (rdbi && rinv) ? ~rbyte : rbyte;
		assign ln_rdmi[g] = rdbi && rinv;
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic lk_rise;
		logic dqs_edge;
		logic hit;
		logic [31:0] rdat;
		logic ill_set;
		lk_rise = 1'b0;
		ill_set = 1'b0;
		dqs_edge = 1'b0;
		hit = 1'b0;
		rdat = 32'h0000_0000;
		st_nxt = st_r;
		// pins pass two flops before use
		st_nxt.lk_sync = {st_r.lk_sync[1:0], link_clk_in};
		st_nxt.cmd_m = cmd_in;
		st_nxt.cmd_q = st_r.cmd_m;
		st_nxt.dqs_sync = {st_r.dqs_sync[1:0], dqs_in};
		st_nxt.dq_m = dq_in;
		st_nxt.dq_q = st_r.dq_m;
		st_nxt.dmi_m = dmi_in;
		st_nxt.dmi_q = st_r.dmi_m;
		lk_rise = st_r.lk_sync[1] & ~st_r.lk_sync[2];
		dqs_edge = st_r.dqs_sync[1] ^ st_r.dqs_sync[2];
		st_nxt.cap_v = 1'b0;

		unique case (st_r.fsm)
			S_IDLE: begin
				if (lk_rise) begin
					st_nxt.fsm = S_PEND;
					unique case (st_r.cmd_q)
						`MWMI_CMD_WR1: st_nxt.kind = K_WR;
						`MWMI_CMD_MW1: st_nxt.kind = K_MW;
						`MWMI_CMD_RD1: st_nxt.kind = K_RD;
						`MWMI_CMD_MRR: st_nxt.kind = K_MRR;
						`MWMI_CMD_MRW: st_nxt.kind = K_MRW;
						`MWMI_CMD_WRFIFO: st_nxt.kind = K_WRFIFO;
						`MWMI_CMD_RDFIFO: st_nxt.kind = K_RDFIFO;
						`MWMI_CMD_RDCAL: st_nxt.kind = K_RDCAL;
						default: st_nxt.fsm = S_IDLE;
					endcase
				end
			end
			S_PEND: begin
				if (lk_rise) begin
					st_nxt.fsm = S_IDLE;
					if (st_r.cmd_q == `MWMI_CMD_CAS2) begin
						if (st_r.kind[2]) begin
							st_nxt.rd_train = (st_r.kind == K_RDFIFO) || (st_r.kind == K_RDCAL);
						end else if (st_r.kind == K_MW && !dm_en) begin
							st_nxt.illegal = 1'b1;
							ill_set = 1'b1;
						end else begin
							st_nxt.fsm = S_BURST;
							st_nxt.beat = 6'h00;
							st_nxt.last_beat = (st_r.kind == K_MW || !st_r.bl32) ?
								`MWMI_LAST_BEAT16 : `MWMI_LAST_BEAT32;
						end
					end
				end
			end
			S_BURST: begin
				if (dqs_edge) begin
					st_nxt.cap_v = 1'b1;
					st_nxt.cap_dq = st_r.dq_q;
					st_nxt.cap_dmi = st_r.dmi_q;
					st_nxt.beat = st_r.beat + 6'h01;
					if (st_r.beat == st_r.last_beat) begin
						st_nxt.fsm = S_IDLE;
					end
				end
			end
		endcase

		// write beat to the array, one cycle after capture
		st_nxt.wr_valid = st_r.cap_v;
		st_nxt.wr_data = ln_wdata;
		st_nxt.wr_mask = ln_wmask;
		st_nxt.wr_dmi = (st_r.kind == K_WRFIFO && any_fn) ? st_r.cap_dmi : 2'h0;

		// read beat onto the pins
		st_nxt.dq_oe = rd_valid_in;
		st_nxt.dq_o = rd_valid_in ? (st_r.rd_train ? rd_data_in : ln_rdata) : 16'h0000;
		if (rd_valid_in && st_r.rd_train && any_fn) begin
			st_nxt.dmi_o = rd_dmi_in;
			st_nxt.dmi_oe = 2'h3;
		end else if (rd_valid_in && !st_r.rd_train && rdbi) begin
			st_nxt.dmi_o = ln_rdmi;
			st_nxt.dmi_oe = 2'h3;
		end else begin
			st_nxt.dmi_o = 2'h0;
			st_nxt.dmi_oe = 2'h0;
		end

		// apb slave: ready one cycle into the access phase
		unique case (paddr)
			`MWMI_OFF_MR3: begin
				hit = 1'b1;
				rdat = {24'h000000, st_r.mr3};
			end
			`MWMI_OFF_MODE_REGISTER_THIRTEEN: begin
				hit = 1'b1;
				rdat = {24'h000000, st_r.mode_register_thirteen};
			end
			`MWMI_OFF_CFG: begin
				hit = 1'b1;
				rdat = {31'h00000000, st_r.bl32};
			end
			`MWMI_OFF_STAT: begin
				hit = 1'b1;
				rdat = {29'h00000000, st_r.rd_train, st_r.fsm == S_BURST, st_r.illegal};
			end
			default: hit = 1'b0;
		endcase
		st_nxt.pready = psel && penable && !st_r.pready;
		st_nxt.pslverr = psel && penable && !st_r.pready && !hit;
		if (psel && penable && !st_r.pready && !pwrite) begin
			st_nxt.prdata = rdat;
		end
		if (psel && penable && st_r.pready && pwrite && hit) begin
			unique case (paddr)
				`MWMI_OFF_MR3: st_nxt.mr3 = pwdata[7:0];
				`MWMI_OFF_MODE_REGISTER_THIRTEEN: st_nxt.mode_register_thirteen = pwdata[7:0];
				`MWMI_OFF_CFG: st_nxt.bl32 = pwdata[`MWMI_CFG_BL32_BIT];
				default: begin
					if (pwdata[`MWMI_STAT_ILL_BIT] && !ill_set) begin
						st_nxt.illegal = 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign dq_out = st_r.dq_o;
	assign dq_oe_out = st_r.dq_oe;
	assign dmi_out = st_r.dmi_o;
	assign dmi_oe_out = st_r.dmi_oe;
	assign wr_valid_out = st_r.wr_valid;
	assign wr_data_out = st_r.wr_data;
	assign wr_mask_out = st_r.wr_mask;
	assign wr_dmi_out = st_r.wr_dmi;
	assign wr_kind_out = st_r.kind;

	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	a_mw_beat_count: assert property (
		(st_r.fsm == S_BURST && st_r.kind == K_MW) |-> st_r.last_beat == `MWMI_LAST_BEAT16)
		else $error("masked write burst is not 16 beats");
	a_two_part_cmd: assert property (
		$rose(st_r.fsm == S_BURST) |-> $past(st_r.fsm == S_PEND && st_r.cmd_q == `MWMI_CMD_CAS2))
		else $error("burst opened without second command cycle");
	a_mw_illegal_set: assert property (
		(st_r.fsm == S_PEND && st_r.lk_sync[1] && !st_r.lk_sync[2] &&
		 st_r.cmd_q == `MWMI_CMD_CAS2 && st_r.kind == K_MW && !dm_en) |=>
		(st_r.illegal && st_r.fsm == S_IDLE))
		else $error("masked write with masking off not flagged");
	a_plain_no_mask: assert property (
		(wr_valid_out && wr_kind_out != K_MW) |-> wr_mask_out == 2'h0)
		else $error("mask applied outside masked write");
	a_mw_dm_mask: assert property (
		(st_r.cap_v && st_r.kind == K_MW && !wdbi) |=> wr_mask_out == $past(st_r.cap_dmi))
		else $error("mask does not follow pin sample");
	a_wr_invert: assert property (
		(st_r.cap_v && st_r.kind == K_WR && wdbi) |=>
		wr_data_out == ($past(st_r.cap_dq) ^ {{8{$past(st_r.cap_dmi[1])}},
			{8{$past(st_r.cap_dmi[0])}}}))
		else $error("write inversion wrong");
	a_mw_dbi_mask: assert property (
		(st_r.cap_v && st_r.kind == K_MW && wdbi) |=>
		wr_mask_out[0] == ($past(!st_r.cap_dmi[0]) && $countones($past(st_r.cap_dq[7:2])) >= 5))
		else $error("masked write with inversion mask wrong");
	a_rd_inv_pin: assert property (
		(dq_oe_out && dmi_oe_out[0] && !st_r.rd_train) |->
		(dmi_out[0] ? ($countones(dq_out[7:0]) < 4) : ($countones(dq_out[7:0]) <= 4)))
		else $error("read inversion count wrong");
	a_rd_hiz: assert property (
		(st_r.dq_oe && !st_r.rd_train && !rdbi) |-> dmi_oe_out == 2'h0)
		else $error("pin driven on read with read inversion off");
	a_apb_ready: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("apb ready not a single cycle");

endmodule

// *** bench/mwmi_host.sv ***
/*
 * host controller model: link clock, two-part commands, write strobe and beats.
 * assumes the bench calls its tasks one at a time.
 */
`timescale 1ns/1ps
`include "mwmi_params.svh"
module mwmi_host (
	output logic lclk_out, // link clock
	output logic [3:0] cmd_out, // command pins
	output logic dqs_out, // write strobe
	output logic [15:0] dq_out, // data pins
	output logic [1:0] dmi_out // mask/invert pins
);
	// ****************************************
	// link clock stands still between frames
	// ****************************************
	initial begin
		lclk_out = 1'h0;
		cmd_out = 4'h0;
		dqs_out = 1'h0;
		dq_out = 16'hA5A5;
		dmi_out = 2'h0;
	end
	// link clocks since the last command; one bank, so one record
	int since_last = 64;
	// every pin change lands 3 ns after a system clock edge, never on it
	task automatic lrise(input logic [3:0] c);
		#3 cmd_out = c;
		#50 lclk_out = 1'h1;
		#100 lclk_out = 1'h0;
		#47;
		since_last++;
	endtask
	task automatic cmd2(input logic [3:0] c1, input logic [3:0] c2);
		while (since_last < `MWMI_MASKED_WRITE_SPACING + `MWMI_BL32_EXTRA) lrise(4'h0);
		lrise(c1);
		lrise(c2);
		since_last = 0;
		#3 cmd_out = ~c2;
		#22;
	endtask
	// idle clocks keep every spacing of the block's single bank
	task automatic idle(input int n);
		repeat (n) lrise(4'h0);
		#3 cmd_out = 4'hF;
		#22;
	endtask
	task automatic beat(input logic [15:0] d, input logic [1:0] m);
		#3 dq_out = d;
		dmi_out = m;
		#100 dqs_out = ~dqs_out;
		#97;
	endtask
	// released pins show the inverse, not a stale value
	task automatic release_bus();
		#3 dq_out = ~dq_out;
		dmi_out = ~dmi_out;
		#22;
	endtask
endmodule

// *** bench/tb.sv ***
/*
 * self-checking bench for the mask/invert lane block.
 * assumes the host model drives the link side, the bench apb and array side.
 */
`timescale 1ns/1ps
`include "mwmi_params.svh"
module tb
	import mwmi_pkg::*;
;
	logic clk_sys_in, reset_in, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic lclk, dqs, dq_oe_out, wr_valid_out, rd_valid_in;
	logic [3:0] cmd;
	logic [15:0] h_dq, dq_w, dq_out, wr_data_out, rd_data_in;
	logic [1:0] h_dmi, dmi_w, dmi_out, dmi_oe_out, wr_mask_out, wr_dmi_out, rd_dmi_in;
	logic [2:0] wr_kind_out;
	logic [22:0] got_q[$], exp_q[$];
	logic [7:0] tbl[4] = '{8'hFC, 8'h3C, 8'h7C, 8'h01};
	logic [15:0] rtbl[4] = '{16'hF80F, 16'h1FFF, 16'h0000, 16'hF0F1};
	int n_fail, comparisons;

	assign dq_w = (dq_oe_out === 1'h1) ? dq_out : h_dq;
	assign dmi_w[0] = (dmi_oe_out[0] === 1'h1) ? dmi_out[0] : h_dmi[0];
	assign dmi_w[1] = (dmi_oe_out[1] === 1'h1) ? dmi_out[1] : h_dmi[1];

	mwmi_top mwmi_top_i (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .link_clk_in(lclk), .cmd_in(cmd), .dqs_in(dqs),
		.dq_in(dq_w), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dmi_in(dmi_w), .dmi_out(dmi_out),
		.dmi_oe_out(dmi_oe_out), .wr_valid_out(wr_valid_out), .wr_data_out(wr_data_out),
		.wr_mask_out(wr_mask_out), .wr_dmi_out(wr_dmi_out), .wr_kind_out(wr_kind_out),
		.rd_valid_in(rd_valid_in), .rd_data_in(rd_data_in), .rd_dmi_in(rd_dmi_in));
	mwmi_host mwmi_host_i (.lclk_out(lclk), .cmd_out(cmd), .dqs_out(dqs), .dq_out(h_dq),
		.dmi_out(h_dmi));

	initial begin
		clk_sys_in = 1'h0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	always @(posedge clk_sys_in) if (wr_valid_out === 1'h1)
		got_q.push_back({wr_dmi_out, wr_mask_out, wr_kind_out, wr_data_out});

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic chk(input string s, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", s, ex, got);
		end
	endtask
	task automatic wrap_up();
		if (n_fail == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	function automatic int ones(input logic [7:0] v);
		int c;
		c = 0;
		for (int i = 0; i < 8; i++) c += v[i];
		return c;
	endfunction
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk_sys_in);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_in);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (pready !== 1'h1 && n < 20);
		if (pready !== 1'h1) begin
			n_fail++;
			wrap_up();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic wreg(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask
	task automatic rchk(input string s, input logic [11:0] a, input logic [31:0] ex,
		input logic [31:0] mk = 32'hFFFFFFFF);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk(s, ex, r & mk);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		logic [31:0] r;
		logic e;
		for (int i = 0; i < 4; i++) rchk("reg reset", 12'(i * 4), 32'h0);
		wreg(`MWMI_OFF_MR3, 32'hC0);
		rchk("mode three", `MWMI_OFF_MR3, 32'hC0);
		apb(1'h0, 12'h010, 32'h0, r, e);
		chk("unmapped error", 32'h1, 32'(e));
		chk("unmapped data", 32'h0, r);
	endtask
	task automatic wr_case(input logic [3:0] c, input mwmi_kind_t k, input logic [7:0] m3,
		input logic [7:0] m13, input logic b32, input int n);
		logic [15:0] d, x;
		logic [1:0] m, mk, dm;
		logic [22:0] g, e;
		wreg(`MWMI_OFF_MR3, {24'h0, m3});
		wreg(`MWMI_OFF_MODE_REGISTER_THIRTEEN, {24'h0, m13});
		wreg(`MWMI_OFF_CFG, {31'h0, b32});
		got_q.delete();
		exp_q.delete();
		mwmi_host_i.cmd2(c, `MWMI_CMD_CAS2);
		for (int i = 0; i < n; i++) begin
			d = {tbl[(i + 1) % 4], tbl[i % 4]};
			m = 2'(i) ^ {1'(i >> 2), 1'h0};
			x = d;
			mk = 2'h0;
			dm = 2'h0;
			for (int l = 0; l < 2; l++) begin
				if (c == `MWMI_CMD_MW1)
					mk[l] = m3[7] ? (!m[l] && ones({2'h0, d[8 * l + 2 +: 6]}) >= 5) : m[l];
				if (c == `MWMI_CMD_WRFIFO) dm[l] = (m3[7] | m3[6] | !m13[5]) & m[l];
				else if (m3[7] && m[l] && !mk[l]) x[8 * l +: 8] = ~d[8 * l +: 8];
				if (mk[l]) x[8 * l +: 8] = 8'h00;
			end
			exp_q.push_back({dm, mk, k, x});
			mwmi_host_i.beat(d, m);
		end
		mwmi_host_i.release_bus();
		repeat (10) @(posedge clk_sys_in);
		chk("beat count", n, got_q.size());
		for (int i = 0; i < got_q.size() && i < n; i++) begin
			e = exp_q[i];
			g = got_q[i];
			if (e[19]) g[7:0] = 8'h00;
			if (e[20]) g[15:8] = 8'h00;
			chk("write beat", 32'(e), 32'(g));
		end
		mwmi_host_i.idle(40);
	endtask
	task automatic t_illegal();
		wreg(`MWMI_OFF_MR3, 32'h0);
		wreg(`MWMI_OFF_MODE_REGISTER_THIRTEEN, 32'h20);
		mwmi_host_i.cmd2(`MWMI_CMD_MW1, `MWMI_CMD_CAS2);
		repeat (16) mwmi_host_i.beat(16'h0F0F, 2'h1);
		mwmi_host_i.release_bus();
		mwmi_host_i.idle(40);
		rchk("illegal flag", `MWMI_OFF_STAT, 32'h1, 32'h1);
		wreg(`MWMI_OFF_STAT, 32'h1);
		rchk("illegal flag clear", `MWMI_OFF_STAT, 32'h0, 32'h1);
		wreg(`MWMI_OFF_MODE_REGISTER_THIRTEEN, 32'h0);
		got_q.delete();
		mwmi_host_i.cmd2(`MWMI_CMD_MW1, 4'h0);
		repeat (16) mwmi_host_i.beat(16'hF0F0, 2'h2);
		mwmi_host_i.release_bus();
		repeat (10) @(posedge clk_sys_in);
		chk("dropped command", 32'h0, got_q.size());
		mwmi_host_i.idle(40);
	endtask
	task automatic rd_case(input logic [3:0] c, input logic [7:0] m3, input logic [7:0] m13);
		logic [15:0] v, x;
		logic [1:0] j, mask_invert_pin, oe;
		logic trn;
		wreg(`MWMI_OFF_MR3, {24'h0, m3});
		wreg(`MWMI_OFF_MODE_REGISTER_THIRTEEN, {24'h0, m13});
		trn = (c == `MWMI_CMD_RDFIFO) || (c == `MWMI_CMD_RDCAL);
		oe = (trn ? (m3[7] | m3[6] | !m13[5]) : m3[6]) ? 2'h3 : 2'h0;
		mwmi_host_i.cmd2(c, `MWMI_CMD_CAS2);
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_sys_in);
			rd_valid_in <= (i < 4);
			rd_data_in <= rtbl[i % 4];
			rd_dmi_in <= 2'(i);
			#1;
			if (i > 0 && i < 5) begin
				j = 2'(i - 1);
				v = rtbl[j];
				x = v;
				mask_invert_pin = trn ? j : 2'h0;
				for (int l = 0; l < 2; l++) begin
					if (!trn && m3[6] && ones(v[8 * l +: 8]) > 4) begin
						x[8 * l +: 8] = ~v[8 * l +: 8];
						mask_invert_pin[l] = 1'h1;
					end
				end
				chk("read data", 32'(x), 32'(dq_out));
				chk("read enables", {29'h0, oe, 1'h1}, {29'h0, dmi_oe_out, dq_oe_out});
				chk("read mask pin", 32'(mask_invert_pin & oe), 32'(dmi_out & oe));
			end
		end
		chk("read release", 32'h0, {29'h0, dmi_oe_out, dq_oe_out});
		rchk("read context", `MWMI_OFF_STAT, {29'h0, trn, 2'h0}, 32'h6);
		mwmi_host_i.idle(16);
	endtask

	initial begin
		n_fail = 0;
		comparisons = 0;
		reset_in = 1'h1;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rd_valid_in = 1'h0;
		rd_data_in = 16'h0;
		rd_dmi_in = 2'h0;
		repeat (16) @(posedge clk_sys_in);
		reset_in <= 1'h0;
		repeat (4) @(posedge clk_sys_in);
		t_regs();
		wr_case(`MWMI_CMD_WR1, K_WR, 8'h00, 8'h00, 1'h0, 16);
		wr_case(`MWMI_CMD_WR1, K_WR, 8'h80, 8'h20, 1'h1, 32);
		wr_case(`MWMI_CMD_MW1, K_MW, 8'h00, 8'h00, 1'h1, 16);
		wr_case(`MWMI_CMD_MW1, K_MW, 8'hC0, 8'h00, 1'h0, 16);
		wr_case(`MWMI_CMD_MRW, K_MRW, 8'h80, 8'h00, 1'h0, 16);
		wr_case(`MWMI_CMD_WRFIFO, K_WRFIFO, 8'h40, 8'h20, 1'h0, 16);
		t_illegal();
		rd_case(`MWMI_CMD_RD1, 8'h00, 8'h20);
		rd_case(`MWMI_CMD_RD1, 8'h40, 8'h20);
		rd_case(`MWMI_CMD_MRR, 8'h40, 8'h00);
		rd_case(`MWMI_CMD_RD1, 8'h80, 8'h00);
		rd_case(`MWMI_CMD_RDFIFO, 8'h00, 8'h00);
		wrap_up();
	end
endmodule
